/* design/serial_audio_port_clocking.sv */
`timescale 1ns/10ps
// Overview of operation
// - Right-justified framing: frame clock high for left slot, low for right slot.
// - Bit clock runs at 64 times sample rate, 32 bits per slot.
// - Right-justified 24-bit word starts eight bit periods after the frame change.
// - Right-justified LSB always sits in the last bit before the frame change.
// - Words go MSB first, each bit valid at the rising bit clock edge.
// - Receiver ignores unused leading positions of short right-justified words.
// - Without I2S on either port, input to output latency is two samples.
// - I2S periods start on frame clock fall, other framings on the rise.
// - One port I2S: output window sits half a period from the input window.
// - I2S conversion latency is 1.5 or 2.5 samples, fixed per setup.
// - Master clock normally feeds the loop; a bypass drives the core directly.
// - Sample rate changes on a fixed master clock keep operation and registers.
// - In master mode the port makes bit and frame clocks from the crystal.
// - In slave mode clocks are inputs and output clocks follow them.
// - Slave two-in two-out uses multiplier 5.5, 2816 core clocks per sample.
// - I2S: frame low for left, high for right, data one bit after change.
// - Left-justified: first data bit in the same period as the frame change.
// - Transmit bits launch on falling bit clock, receive bits sample on rising.
module serial_audio_port_clocking #(
    parameter int BCLK_HALF = sap_pkg::BCLK_HALF_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire sap_pkg::apb_req_t apb_req,
    output sap_pkg::apb_rsp_t apb_rsp,
    input wire logic bit_clock_in,
    input wire logic frame_clock_in,
    input wire logic serial_audio_input,
    output logic bit_clock_out,
    output logic frame_clock_out,
    output logic serial_audio_output,
    output logic core_clock_bypass
);
    import sap_pkg::*;

    ctrl_t ctrl_r;
    logic [7:0] div_r;
    logic gen_bclk_r;
    logic [5:0] gen_cnt_r;
    logic bclk_last_r;
    logic fclk_last_r;
    logic [4:0] pos_r;
    logic [23:0] rx_sh_r;
    logic [23:0] rx_left_r;
    logic [23:0] rx_right_r;
    logic [47:0] proc_r;
    logic [47:0] procd_r;
    logic [23:0] tx_left_r;
    logic [23:0] tx_right_r;
    logic sdo_r;
    logic bclk_out_r;
    logic fclk_out_r;
    logic bypass_r;
    logic [15:0] sample_cnt_r;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;

    // Effective output settings follow the input unless separately configured.
    fmt_t out_fmt;
    wlen_t out_wlen;
    logic in_i2s;
    logic out_i2s;
    logic mixed;
    logic [5:0] in_len;
    logic [5:0] out_len;
    logic [5:0] out_first;
    assign out_fmt = ctrl_r.separate ? ctrl_r.out_fmt : ctrl_r.in_fmt;
    assign out_wlen = ctrl_r.separate ? ctrl_r.out_wlen : ctrl_r.in_wlen;
    assign in_i2s = (ctrl_r.in_fmt == FMT_I2S);
    assign out_i2s = (out_fmt == FMT_I2S);
    assign mixed = in_i2s ^ out_i2s;
    assign in_len = word_len(ctrl_r.in_wlen);
    assign out_len = word_len(out_wlen);
    assign out_first = first_pos(out_fmt, out_len);

    // Master bit clock: pclk stands in for the crystal; the divider sets the rate.
    logic div_end;
    assign div_end = (div_r == 8'(BCLK_HALF - 1));
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_r <= 8'h00;
            gen_bclk_r <= 1'b0;
            gen_cnt_r <= 6'h00;
        end else if (ctrl_r.master) begin
            div_r <= div_end ? 8'h00 : div_r + 8'h01;
            if (div_end) begin
                gen_bclk_r <= ~gen_bclk_r;
                gen_cnt_r <= gen_bclk_r ? gen_cnt_r + 6'h01 : gen_cnt_r;
            end
        end
    end

    // Line levels: generated in master mode, taken from the pins in slave mode.
    logic bclk_lvl;
    logic fclk_lvl;
    logic gen_fclk;
    assign gen_fclk = ~gen_cnt_r[5] ^ in_i2s ^ ctrl_r.frame_invert;
    assign bclk_lvl = ctrl_r.master ? gen_bclk_r : bit_clock_in;
    assign fclk_lvl = ctrl_r.master ? gen_fclk : frame_clock_in;

    // Bit clock edges and slot position; a frame change restarts the slot count.
    logic bit_rise;
    logic bit_fall;
    logic fchg;
    logic left_now;
    logic in_start;
    logic [4:0] pos_nxt;
    assign bit_rise = bclk_lvl & ~bclk_last_r;
    assign bit_fall = ~bclk_lvl & bclk_last_r;
    assign fchg = fclk_lvl ^ fclk_last_r;
    assign left_now = fclk_lvl ^ in_i2s ^ ctrl_r.frame_invert;
    assign in_start = bit_rise & fchg & left_now;
    assign pos_nxt = fchg ? 5'h00 : pos_r + 5'h01;

    // Receive side: bits outside the word window are skipped, MSB shifts in first.
    logic rx_use;
    logic [23:0] rx_aligned;
    logic [23:0] rx_sh_nxt;
    assign rx_use = in_word(ctrl_r.in_fmt, in_len, pos_nxt);
    assign rx_aligned = rx_sh_r << (WORD_BITS - in_len);
    assign rx_sh_nxt = fchg ? (rx_use ? {23'h000000, serial_audio_input} : 24'h000000)
                            : (rx_use ? {rx_sh_r[22:0], serial_audio_input} : rx_sh_r);

    // Sampling happens on the rising bit edge; slot words close at the frame change.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bclk_last_r <= 1'b0;
            fclk_last_r <= 1'b0;
            pos_r <= 5'h00;
            rx_sh_r <= 24'h000000;
            rx_left_r <= 24'h000000;
            rx_right_r <= 24'h000000;
            proc_r <= 48'h000000000000;
            procd_r <= 48'h000000000000;
            sample_cnt_r <= 16'h0000;
        end else begin
            bclk_last_r <= bclk_lvl;
            if (bit_rise) begin
                fclk_last_r <= fclk_lvl;
                pos_r <= pos_nxt;
                rx_sh_r <= rx_sh_nxt;
                if (fchg && !left_now) begin
                    rx_left_r <= rx_aligned;
                end
                if (in_start) begin
                    // Core stage takes the pair, the older pair moves one stage on.
                    rx_right_r <= rx_aligned;
                    proc_r <= {rx_left_r, rx_aligned};
                    procd_r <= proc_r;
                    sample_cnt_r <= sample_cnt_r + 16'h0001;
                end
            end
        end
    end

    // Transmit side predicts the next slot position so the bit is out before the rise.
    logic out_left_now;
    logic next_left;
    logic out_load;
    logic [4:0] npos;
    logic [47:0] tx_src;
    logic [23:0] tx_word;
    logic [5:0] tx_idx;
    logic tx_use;
    assign out_left_now = fclk_last_r ^ out_i2s ^ ctrl_r.frame_invert;
    assign next_left = (pos_r == 5'h1F) ? ~out_left_now : out_left_now;
    assign out_load = bit_fall & (pos_r == 5'h1F) & ~out_left_now;
    assign npos = pos_r + 5'h01;
    assign tx_src = (mixed && ctrl_r.late_mid) ? procd_r : proc_r;
    assign tx_word = next_left ? (out_load ? tx_src[47:24] : tx_left_r) : tx_right_r;
    assign tx_use = in_word(out_fmt, out_len, npos);
    assign tx_idx = 6'h17 - ({1'b0, npos} - out_first);

    // Output window loads on its own period start; with one I2S port that is mid-period.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_left_r <= 24'h000000;
            tx_right_r <= 24'h000000;
            sdo_r <= 1'b0;
        end else if (bit_fall) begin
            if (out_load) begin
                tx_left_r <= tx_src[47:24];
                tx_right_r <= tx_src[23:0];
            end
            sdo_r <= tx_use ? tx_word[tx_idx[4:0]] : 1'b0;
        end
    end

    // Output clocks are registered copies so they line up with the launched data.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bclk_out_r <= 1'b0;
            fclk_out_r <= 1'b0;
            bypass_r <= 1'b0;
        end else begin
            bclk_out_r <= bclk_lvl;
            fclk_out_r <= fclk_lvl;
            bypass_r <= ctrl_r.pll_bypass;
        end
    end

    assign bit_clock_out = bclk_out_r;
    assign frame_clock_out = fclk_out_r;
    assign serial_audio_output = sdo_r;
    assign core_clock_bypass = bypass_r;

    // APB decode; answer comes in the first access cycle, unmapped offsets error.
    logic setup;
    logic access;
    logic hit;
    logic [31:0] rd_data;
    assign setup = apb_req.psel & ~apb_req.penable;
    assign access = apb_req.psel & apb_req.penable & pready_r;
    assign hit = (apb_req.paddr == CTRL_OFS) || (apb_req.paddr == STATUS_OFS) ||
                 (apb_req.paddr == CLOCKING_OFS) || (apb_req.paddr == RX_LEFT_OFS) ||
                 (apb_req.paddr == RX_RIGHT_OFS);

    // Read mux; status shows live slot position and sample count.
    always_comb begin
        case (apb_req.paddr)
            CTRL_OFS: rd_data = {19'h00000, ctrl_r};
            STATUS_OFS: rd_data = {11'h000, pos_r, sample_cnt_r};
            CLOCKING_OFS: rd_data = {4'h0, CORE_CYCLES_PER_SAMPLE, 12'h000, PLL_MULT_X2};
            RX_LEFT_OFS: rd_data = {8'h00, rx_left_r};
            RX_RIGHT_OFS: rd_data = {8'h00, rx_right_r};
            default: rd_data = 32'h00000000;
        endcase
    end

    // Registers keep their contents across rate changes; only reset reloads them, the control register with CTRL_RESET.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= ctrl_t'(CTRL_RESET);
            prdata_r <= 32'h00000000;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            pready_r <= setup;
            if (setup) begin
                prdata_r <= rd_data;
                pslverr_r <= ~hit;
            end
            if (access && apb_req.pwrite && apb_req.paddr == CTRL_OFS) begin
                ctrl_r <= ctrl_t'(apb_req.pwdata[CTRL_BITS-1:0]);
            end
        end
    end

    assign apb_rsp = '{prdata: prdata_r, pready: pready_r, pslverr: pslverr_r};

    a_slot_count: assert property (@(posedge pclk) disable iff (!presetn)
        (bit_rise && !fchg) |=> (pos_r == $past(pos_r) + 5'h01))
        else $error("slot position did not advance");
    a_slot_restart: assert property (@(posedge pclk) disable iff (!presetn)
        (bit_rise && fchg) |=> (pos_r == 5'h00))
        else $error("slot position not restarted at frame change");
    a_rj_first_bit: assert property (@(posedge pclk) disable iff (!presetn)
        (bit_rise && ctrl_r.in_fmt == FMT_RJ && in_len == 6'h18 && pos_nxt == 5'h08) |-> rx_use)
        else $error("right-justified 24-bit word not started at position 8");
    a_rj_lsb_last: assert property (@(posedge pclk) disable iff (!presetn)
        (bit_rise && ctrl_r.in_fmt == FMT_RJ && pos_nxt == 5'h1F) |-> rx_use)
        else $error("right-justified LSB not in last slot bit");
    a_rj_lead_skip: assert property (@(posedge pclk) disable iff (!presetn)
        (ctrl_r.in_fmt == FMT_RJ && {1'b0, pos_nxt} < SLOT_BITS - in_len) |-> !rx_use)
        else $error("leading unused position taken as data");
    a_launch_fall: assert property (@(posedge pclk) disable iff (!presetn)
        !$past(bit_fall) |-> $stable(sdo_r))
        else $error("output data changed away from a falling bit edge");
    a_period_edge: assert property (@(posedge pclk) disable iff (!presetn)
        in_start |-> (fclk_lvl == ~(in_i2s ^ ctrl_r.frame_invert)))
        else $error("sample period started on the wrong frame edge");
    a_two_sample: assert property (@(posedge pclk) disable iff (!presetn)
        (out_load && !mixed) |=> (tx_left_r == $past(proc_r[47:24])))
        else $error("non-I2S path did not load the core stage");
    a_late_half: assert property (@(posedge pclk) disable iff (!presetn)
        (out_load && mixed && ctrl_r.late_mid) |=> (tx_right_r == $past(procd_r[23:0])))
        else $error("late midpoint did not take the older pair");
    a_slave_follow: assert property (@(posedge pclk) disable iff (!presetn)
        (!ctrl_r.master && !$past(ctrl_r.master)) |-> (bit_clock_out == $past(bit_clock_in)))
        else $error("slave output bit clock does not follow input");
    a_bypass_path: assert property (@(posedge pclk) disable iff (!presetn)
        $changed(ctrl_r.pll_bypass) |=> (core_clock_bypass == $past(ctrl_r.pll_bypass)))
        else $error("bypass select not applied");

endmodule : serial_audio_port_clocking

/* design/sap_pkg.sv */
package sap_pkg;

    // Register byte offsets on the APB side.
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] CLOCKING_OFS = 8'h08;
    localparam logic [7:0] RX_LEFT_OFS = 8'h0C;
    localparam logic [7:0] RX_RIGHT_OFS = 8'h10;

    // Serial framing codes and word length codes.
    typedef enum logic [1:0] {FMT_LJ = 2'b00, FMT_RJ = 2'b01, FMT_I2S = 2'b10, FMT_RSVD = 2'b11} fmt_t;
    typedef enum logic [1:0] {WL_RSVD = 2'b00, WL_16 = 2'b01, WL_20 = 2'b10, WL_24 = 2'b11} wlen_t;

    // Control register layout, bit 0 first from the bottom.
    typedef struct packed {
        logic frame_invert;
        logic late_mid;
        logic pll_bypass;
        logic separate;
        wlen_t out_wlen;
        wlen_t in_wlen;
        fmt_t out_fmt;
        fmt_t in_fmt;
        logic master;
    } ctrl_t;
    localparam int CTRL_BITS = 13;
    localparam logic [12:0] CTRL_RESET = 13'h01E0;

    // APB request and answer bundles.
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;
    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } apb_rsp_t;

    // Slot geometry, clocking figures and the master bit clock divider.
    localparam logic [5:0] SLOT_BITS = 6'h20;
    localparam logic [5:0] WORD_BITS = 6'h18;
    localparam logic [3:0] PLL_MULT_X2 = 4'hB;
    localparam logic [11:0] CORE_CYCLES_PER_SAMPLE = 12'hB00;
    localparam int BCLK_HALF_CYCLES = 7;

    // Word length in bits; the reserved code falls back to 24.
    function automatic logic [5:0] word_len(wlen_t w);
        case (w)
            WL_16: return 6'h10;
            WL_20: return 6'h14;
            default: return WORD_BITS;
        endcase
    endfunction : word_len

    // Slot position of the first data bit for a framing and length.
    function automatic logic [5:0] first_pos(fmt_t f, logic [5:0] len);
        case (f)
            FMT_RJ: return SLOT_BITS - len;
            FMT_I2S: return 6'h01;
            default: return 6'h00;
        endcase
    endfunction : first_pos

    // True when a slot position carries a data bit of the word.
    function automatic logic in_word(fmt_t f, logic [5:0] len, logic [4:0] pos);
        logic [5:0] s;
        s = first_pos(f, len);
        return ({1'b0, pos} >= s) && ({1'b0, pos} < s + len);
    endfunction : in_word

endpackage : sap_pkg

/* test/audio_link_partner.sv */
`timescale 1ns/10ps
// Far-side source and sink for slave-mode serial audio; its bit clock runs free between frames.
module audio_link_partner (
    input logic pclk,
    input logic presetn,
    input logic [2:0] half,
    input sap_pkg::fmt_t in_fmt,
    input sap_pkg::fmt_t out_fmt,
    input logic [5:0] len,
    input logic inv,
    output logic bit_clock_in,
    output logic frame_clock_in,
    output logic serial_audio_input,
    input logic bit_clock_out,
    input logic frame_clock_out,
    input logic serial_audio_output,
    output logic [12:0] lat,
    output logic [23:0] cap_l,
    output logic [7:0] errs
);
    import sap_pkg::*;
    logic [2:0] cnt_r;
    logic [5:0] pos_r, pos_nxt, ft, fr;
    logic [12:0] slot_r, slot_nxt, ostart_r;
    logic [23:0] word, sr_r, sr_nxt, cw;
    logic [4:0] oq_r, oq_nxt;
    logic bco_r, fco_r, sdo_r;

    // First slot position of the word for a framing.
    function automatic logic [5:0] first(fmt_t f);
        return f == FMT_RJ ? 6'h20 - len : (f == FMT_I2S ? 6'h01 : 6'h00);
    endfunction : first

    // Words carry the pair number in their top bits, so latency can be read back at the sink.
    // Left slots always carry odd slot numbers, so a left word came from slot 2 * pair + 1.
    assign pos_nxt = pos_r + 6'h01;
    assign slot_nxt = slot_r + {12'h000, pos_nxt[4:0] == 5'h00};
    assign word = {slot_nxt[12:1], pos_nxt[5] ? 12'h3D6 : 12'hA5C};
    assign ft = {1'h0, pos_nxt[4:0]} - first(in_fmt);
    assign oq_nxt = (frame_clock_out != fco_r) ? 5'h00 : oq_r + 5'h01;
    assign fr = {1'h0, oq_nxt} - first(out_fmt);
    assign sr_nxt = fr < len ? {sr_r[22:0], serial_audio_output} : sr_r;
    assign cw = sr_nxt << (6'h18 - len);

    // Bits and frame level launch on the falling bit clock; unused positions toggle, as no pull holds them.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {cnt_r, slot_r, bit_clock_in, frame_clock_in, serial_audio_input} <= '0;
            pos_r <= 6'h3F;
        end else if (cnt_r + 3'h1 >= half) begin
            cnt_r <= 3'h0;
            bit_clock_in <= ~bit_clock_in;
            if (bit_clock_in) begin
                pos_r <= pos_nxt;
                slot_r <= slot_nxt;
                frame_clock_in <= pos_nxt[5] ^ (in_fmt != FMT_I2S) ^ inv;
                serial_audio_input <= ft < len ? word[5'h17 - ft[4:0]] : ~serial_audio_input;
            end
        end else begin
            cnt_r <= cnt_r + 3'h1;
        end
    end

    // The sink samples on the rising output bit clock and counts data that moves while that clock is high.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {bco_r, fco_r, sdo_r, oq_r, sr_r, ostart_r, lat, cap_l, errs} <= '0;
        end else begin
            bco_r <= bit_clock_out;
            sdo_r <= serial_audio_output;
            if (serial_audio_output != sdo_r && bit_clock_out && bco_r) errs <= errs + 8'h01;
            if (bit_clock_out && !bco_r) begin
                fco_r <= frame_clock_out;
                oq_r <= oq_nxt;
                sr_r <= sr_nxt;
                if (oq_nxt == 5'h00) ostart_r <= slot_r;
                if (oq_nxt == 5'h1F && frame_clock_out == ((out_fmt != FMT_I2S) ^ inv)) begin
                    cap_l <= cw;
                    lat <= ostart_r - {cw[23:12], 1'h1};
                end
            end
        end
    end
endmodule : audio_link_partner

/* test/serial_audio_port_clocking_tb.sv */
`timescale 1ns/10ps
// Register cases first, then slave-mode framing rows, then rate change, bypass, master clock and reset cases.
module serial_audio_port_clocking_tb;
    import sap_pkg::*;
    localparam int BH = 2;
    typedef struct packed {
        fmt_t fi;
        fmt_t fo;
        wlen_t wl;
        logic [5:0] len;
        logic [2:0] flags;
        logic [12:0] lat;
    } row_t;
    // Flags are separate, late midpoint and frame invert; lat is the delay in channel slots.
    localparam row_t ROWS [10] = '{
        '{FMT_LJ, FMT_LJ, WL_24, 6'h18, 3'h0, 13'h4}, '{FMT_RJ, FMT_RJ, WL_24, 6'h18, 3'h0, 13'h4},
        '{FMT_RJ, FMT_RJ, WL_16, 6'h10, 3'h4, 13'h4}, '{FMT_RJ, FMT_RJ, WL_20, 6'h14, 3'h1, 13'h4},
        '{FMT_I2S, FMT_I2S, WL_24, 6'h18, 3'h5, 13'h4}, '{FMT_LJ, FMT_LJ, WL_RSVD, 6'h18, 3'h4, 13'h4},
        '{FMT_LJ, FMT_I2S, WL_20, 6'h14, 3'h4, 13'h3}, '{FMT_LJ, FMT_I2S, WL_24, 6'h18, 3'h6, 13'h5},
        '{FMT_I2S, FMT_RJ, WL_16, 6'h10, 3'h4, 13'h3}, '{FMT_I2S, FMT_LJ, WL_24, 6'h18, 3'h6, 13'h5}};
    logic pclk, presetn, bit_clock_in, frame_clock_in, serial_audio_input;
    logic bit_clock_out, frame_clock_out, serial_audio_output, core_clock_bypass, pinv;
    apb_req_t req;
    apb_rsp_t rsp;
    logic [2:0] half;
    fmt_t pfi, pfo;
    logic [5:0] plen;
    logic [12:0] p_lat;
    logic [23:0] p_cap;
    logic [7:0] p_errs;
    int fails = 0;
    int tests_run = 0;

    serial_audio_port_clocking #(.BCLK_HALF(BH)) i_serial_audio_port_clocking (.pclk, .presetn,
        .apb_req(req), .apb_rsp(rsp), .bit_clock_in, .frame_clock_in, .serial_audio_input,
        .bit_clock_out, .frame_clock_out, .serial_audio_output, .core_clock_bypass);
    audio_link_partner i_audio_link_partner (.pclk, .presetn, .half, .in_fmt(pfi), .out_fmt(pfo),
        .len(plen), .inv(pinv), .bit_clock_in, .frame_clock_in, .serial_audio_input, .bit_clock_out,
        .frame_clock_out, .serial_audio_output, .lat(p_lat), .cap_l(p_cap), .errs(p_errs));

    // Compare, count and report at once.
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    // One APB transfer; the request holds until pready is seen high at a rising edge.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd,
                       output logic er);
        @(posedge pclk);
        req <= '{psel: 1'h1, penable: 1'h0, pwrite: w, paddr: a, pwdata: wd};
        @(posedge pclk);
        req.penable <= 1'h1;
        // Waits as long as the slave needs; only the watchdog ends a hang.
        do begin
            @(posedge pclk);
        end while (rsp.pready !== 1'h1);
        rd = rsp.prdata;
        er = rsp.pslverr;
        req <= '0;
    endtask : apb

    // Eight frames at the slowest bit clock used, long enough for the pipeline to refill.
    task automatic settle();
        repeat (3072) @(posedge pclk);
    endtask : settle

    // Counts clock cycles while the output frame clock stays at one level.
    task automatic hold_len(input logic lvl, output int n);
        n = 0;
        while (frame_clock_out === lvl && n < 1000) begin
            @(negedge pclk);
            n++;
        end
    endtask : hold_len

    // The single place where the run ends.
    task automatic results();
        $display("Comparisons %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : results

    // A single master clock source drives the block; an unused second source would sit at zero.
    initial begin
        pclk = 1'h0;
        forever #12.5 pclk = ~pclk;
    end

    // A hang is cut short well after the expected run of about 34500 cycles.
    initial begin
        repeat (60000) @(posedge pclk);
        fails++;
        results();
    end

    initial begin
        logic [31:0] d, cw;
        logic [23:0] m;
        logic e, b;
        int hi, lo;
        row_t r;
        {presetn, pinv, req} = '0;
        half = 3'h2;
        pfi = FMT_LJ;
        pfo = FMT_LJ;
        plen = 6'h18;
        repeat (20) @(posedge pclk);
        check({30'h0, serial_audio_output, core_clock_bypass}, 32'h0);
        presetn <= 1'h1;
        apb(1'h0, CTRL_OFS, 32'h0, d, e);
        check(d, {19'h0, CTRL_RESET});
        apb(1'h1, CLOCKING_OFS, 32'hFFFFFFFF, d, e);
        apb(1'h0, CLOCKING_OFS, 32'h0, d, e);
        check(d, 32'h0B00000B);
        apb(1'h0, 8'h14, 32'h0, d, e);
        check({e, d[30:0]}, 32'h80000000);
        foreach (ROWS[i]) begin
            r = ROWS[i];
            cw = {19'h0, r.flags[0], r.flags[1], 1'h0, r.flags[2], r.wl, r.wl,
                  r.flags[2] ? r.fo : fmt_t'(~r.fi), r.fi, 1'h0};
            @(posedge pclk);
            pfi <= r.fi;
            pfo <= r.flags[2] ? r.fo : r.fi;
            plen <= r.len;
            pinv <= r.flags[0];
            apb(1'h1, CTRL_OFS, cw, d, e);
            settle();
            m = 24'hFFFFFF << (6'h18 - r.len);
            check({19'h0, p_lat}, {19'h0, r.lat});
            check({20'h0, p_cap[11:0]}, {20'h0, m[11:0] & 12'hA5C});
            apb(1'h0, RX_LEFT_OFS, 32'h0, d, e);
            check({d[31:24], 12'h0, d[11:0]}, {20'h0, m[11:0] & 12'hA5C});
            apb(1'h0, RX_RIGHT_OFS, 32'h0, d, e);
            check({d[31:24], 12'h0, d[11:0]}, {20'h0, m[11:0] & 12'h3D6});
            @(negedge pclk) b = bit_clock_in;
            @(negedge pclk) check({31'h0, bit_clock_out}, {31'h0, b});
        end
        // Sample rate change on a fixed pclk; the settle wait covers the span firmware would keep muted.
        half <= 3'h3;
        settle();
        check({19'h0, p_lat}, {19'h0, r.lat});
        apb(1'h0, CTRL_OFS, 32'h0, d, e);
        check(d, cw);
        check({24'h0, p_errs}, 32'h0);
        apb(1'h1, CTRL_OFS, cw | 32'h400, d, e);
        repeat (2) @(posedge pclk);
        check({31'h0, core_clock_bypass}, 32'h1);
        apb(1'h1, CTRL_OFS, 32'h000001E1, d, e);
        hold_len(1'h1, hi);
        hold_len(1'h0, lo);
        hold_len(1'h1, hi);
        hold_len(1'h0, lo);
        check(hi, 64 * BH);
        check(lo, 64 * BH);
        // Reset in mid-run, as the system holds it while the master clock changes frequency.
        @(posedge pclk);
        presetn <= 1'h0;
        repeat (4) @(posedge pclk);
        check({30'h0, serial_audio_output, core_clock_bypass}, 32'h0);
        presetn <= 1'h1;
        apb(1'h0, CTRL_OFS, 32'h0, d, e);
        check(d, {19'h0, CTRL_RESET});
        apb(1'h0, RX_LEFT_OFS, 32'h0, d, e);
        check(d, 32'h0);
        results();
    end
endmodule : serial_audio_port_clocking_tb
